// ### inc/dda_pkg.sv
package dda_pkg;

  // ****************************************
  // iteration timing
  // ****************************************
  localparam int CLK_HZ   = 40_000_000;
  localparam int ITER_HZ  = 100_000;
  localparam int ITER_CYC = CLK_HZ / ITER_HZ;
  localparam int TICK_W   = 9;

  // ****************************************
  // variable register format
  // ****************************************
  localparam int REG_W          = 30;
  localparam int SIGN_POS       = 29;
  localparam int BODY_W         = 29;
  localparam int MARK_MIN_TIME  = 1;
  localparam int MARK_MIN_OTHER = 2;

  // remainder: one whole is 2^29, start value is one half
  localparam logic signed [30:0] R_ONE  = 31'sh2000_0000;
  localparam logic signed [30:0] R_HALF = 31'sh1000_0000;

  // ****************************************
  // ternary increments
  // ****************************************
  localparam logic signed [3:0] INC_PLUS  = 4'sh1;
  localparam logic signed [3:0] INC_MINUS = 4'shF;
  localparam logic signed [3:0] INC_ZERO  = 4'sh0;
  localparam int SUM_INPUTS = 6;
  localparam int SEC_INPUTS = 2;

  // ****************************************
  // keyboard fill
  // ****************************************
  localparam int GRP_W      = 3;
  localparam int GRP_TOP    = BODY_W - GRP_W;
  localparam int GRP_MAX    = 10;
  localparam int DEC_DIGITS = 8;
  localparam logic [3:0]  DEC_RADIX = 4'hA;
  localparam logic [27:0] DEC_ONE   = 28'h000_0001;

  // ****************************************
  // converter range
  // ****************************************
  localparam logic signed [14:0] DAC_MAX = 15'sh2000;
  localparam logic signed [14:0] DAC_MIN = 15'sh6000;

  typedef enum {ST_FILL, ST_CONV, ST_RUN, ST_HALT} state_t;

endpackage : dda_pkg

// ### logic/dda_integrator.sv
// What this block does
// - all modules step together, one increment step per iteration at 100,000 per second
// - each variable register is 30 bits holding a sign bit and a scaling bit
// - the sign bit sits in the first, topmost register position
// - a one marks register length; all positions below the marker are zero
// - with machine time secondary, at most 27 computing bits plus sign and scaling
// - with other secondary input, at most 26 computing bits plus sign and scaling
// - sign one means negative; negative contents are in two's complement
// - register contents are signed fractions from minus one up to below one
// - six summer inputs are added and feed only the secondary input, no output
// - integrator without summer has two secondaries, one primary, positive and negative out
// - constant multiplier takes only a primary input and drives both outputs
// - converter ranges are limited to plus or minus 2^13 increments
// - integrand overflow raises an indication and may halt computation automatically
// - eight octal keys each enter the three-bit group of their value
// - decimal entry is converted to binary before loading; last bit may be truncated
// - remainder starts at one half; overflow either way yields an output increment
// - output increment appears exactly one iteration after its primary input
module dda_integrator
  import dda_pkg::*;
(
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_B,
  // mode levels
  input  wire logic        RUN,
  input  wire logic        SUM_EN,
  input  wire logic        SEC_IS_TIME,
  input  wire logic        CONST_MODE,
  input  wire logic        AUTO_HALT,
  // increments, each a plus and minus line
  input  wire logic        PRI_P,
  input  wire logic        PRI_M,
  input  wire logic [1:0]  SEC_P,
  input  wire logic [1:0]  SEC_M,
  input  wire logic [5:0]  SUM_P,
  input  wire logic [5:0]  SUM_M,
  // fill keyboard
  input  wire logic        KEY_STB,
  input  wire logic [2:0]  KEY_VAL,
  input  wire logic        SIGN_STB,
  input  wire logic        CLEAR_STB,
  input  wire logic        DEC_STB,
  input  wire logic [3:0]  DEC_DIGIT,
  input  wire logic        DEC_LOAD,
  // results
  output logic             ITER_STB,
  output logic             OUT_POS_P,
  output logic             OUT_POS_M,
  output logic             OUT_NEG_P,
  output logic             OUT_NEG_M,
  output logic             OVERFLOW,
  output logic             LEN_FAULT,
  output logic             RUNNING,
  output logic [29:0]      Y_READ,
  output logic [14:0]      DAC_LEVEL
);

  // ****************************************
  // input synchronisers
  // ****************************************
  localparam int SYNC_W = 35;

  logic [SYNC_W-1:0] meta_r;
  logic [SYNC_W-1:0] sync_r;
  logic [4:0]        strb_q_r;
  wire  [SYNC_W-1:0] pin_w = {RUN, SUM_EN, SEC_IS_TIME, CONST_MODE, AUTO_HALT, PRI_P, PRI_M,
                              SEC_P, SEC_M, SUM_P, SUM_M, KEY_STB, KEY_VAL, SIGN_STB,
                              CLEAR_STB, DEC_STB, DEC_DIGIT, DEC_LOAD};
  wire        run_s, sum_en_s, sec_time_s, const_s, auto_halt_s, pri_p_s, pri_m_s;
  wire [1:0]  sec_p_s, sec_m_s;
  wire [5:0]  sum_p_s, sum_m_s;
  wire        key_s, sign_s, clr_s, dec_s, load_s;
  wire [2:0]  key_val_s;
  wire [3:0]  digit_s;

  assign {run_s, sum_en_s, sec_time_s, const_s, auto_halt_s, pri_p_s, pri_m_s, sec_p_s,
          sec_m_s, sum_p_s, sum_m_s, key_s, key_val_s, sign_s, clr_s, dec_s, digit_s,
          load_s} = sync_r;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      meta_r   <= '0;
      sync_r   <= '0;
      strb_q_r <= '0;
    end else begin
      meta_r   <= pin_w;
      sync_r   <= meta_r;
      strb_q_r <= {key_s, sign_s, clr_s, dec_s, load_s};
    end
  end

  // keys are levels from the panel; act once per press
  wire key_ev  = key_s & ~strb_q_r[4];
  wire sign_ev = sign_s & ~strb_q_r[3];
  wire clr_ev  = clr_s & ~strb_q_r[2];
  wire dec_ev  = dec_s & ~strb_q_r[1];
  wire load_ev = load_s & ~strb_q_r[0];

  // ****************************************
  // iteration timer
  // ****************************************
  logic [TICK_W-1:0] tick_cnt_r;
  logic              tick_r;
  wire               tick_wrap_w = (tick_cnt_r == TICK_W'(ITER_CYC - 1));

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b0;
    end else begin
      tick_cnt_r <= tick_wrap_w ? '0 : TICK_W'(tick_cnt_r + 1'b1);
      tick_r     <= tick_wrap_w;
    end
  end

  // ****************************************
  // increment decode
  // ****************************************
  function automatic logic signed [3:0] tern(input logic p, input logic m);
    logic signed [3:0] t;
    t = INC_ZERO;
    if (p && !m) t = INC_PLUS;
    else if (m && !p) t = INC_MINUS;
    return t;
  endfunction : tern

  logic signed [3:0] dy_sum;
  always_comb begin
    dy_sum = INC_ZERO;
    if (sum_en_s) begin
      for (int i = 0; i < SUM_INPUTS; i++) dy_sum = dy_sum + tern(sum_p_s[i], sum_m_s[i]);
    end else begin
      for (int i = 0; i < SEC_INPUTS; i++) dy_sum = dy_sum + tern(sec_p_s[i], sec_m_s[i]);
    end
  end

  wire signed [3:0] dy_w = const_s ? INC_ZERO : dy_sum;
  wire signed [3:0] dx_w = tern(pri_p_s, pri_m_s);

  // ****************************************
  // register format
  // ****************************************
  state_t             state_r;
  state_t             state_nxt;
  logic [REG_W-1:0]   y_r;
  logic signed [30:0] r_r;
  logic               ovf_r;

  // marker is the lowest one in the body; below it only zeros
  wire [BODY_W-1:0] body_w   = y_r[BODY_W-1:0];
  wire [BODY_W-1:0] mark_w   = body_w & BODY_W'(~body_w + 1'b1);
  wire [REG_W-1:0]  lsb_w    = {mark_w, 1'b0};
  wire [REG_W-1:0]  hi_mask  = ~REG_W'(lsb_w - 1'b1);
  wire [BODY_W-1:0] low_mask = BODY_W'((BODY_W'(1) << (sec_time_s ? MARK_MIN_TIME
                                                                   : MARK_MIN_OTHER)) - 1);
  wire              len_ok_w = (|mark_w) && ((mark_w & low_mask) == '0);

  // value is a two's complement fraction with the sign on top
  wire signed [REG_W-1:0] y_val_w = $signed(y_r & hi_mask);
  wire signed [30:0]      y_ext_w = {y_val_w[SIGN_POS], y_val_w};

  // ****************************************
  // integration step
  // ****************************************
  wire signed [30:0] ystep_w  = 31'(dy_w * $signed({1'b0, lsb_w}));
  wire signed [30:0] y_sum_w  = y_ext_w + ystep_w;
  wire               y_ovf_w  = y_sum_w[30] != y_sum_w[SIGN_POS];
  wire signed [30:0] r_add_w  = (dx_w == INC_PLUS)  ? y_ext_w :
                                (dx_w == INC_MINUS) ? 31'(-y_ext_w) : '0;
  wire signed [30:0] r_sum_w  = r_r + r_add_w;
  wire               dz_pos_w = (r_sum_w >= R_ONE);
  wire               dz_neg_w = (r_sum_w < 0);
  wire signed [30:0] r_nxt_w  = dz_pos_w ? 31'(r_sum_w - R_ONE) :
                                dz_neg_w ? 31'(r_sum_w + R_ONE) : r_sum_w;
  wire               run_tick = (state_r == ST_RUN) && tick_r;

  // ****************************************
  // fill and decimal conversion
  // ****************************************
  logic [3:0]        grp_cnt_r;
  logic [27:0]       dec_num_r;
  logic [27:0]       dec_p10_r;
  logic [3:0]        dec_cnt_r;
  logic [BODY_W-1:0] frac_r;
  logic [4:0]        conv_cnt_r;

  wire [BODY_W-1:0] key_shift_w = BODY_W'({key_val_s, {GRP_TOP{1'b0}}} >> (GRP_W * grp_cnt_r));
  wire [27:0]       dbl_w       = {dec_num_r[26:0], 1'b0};
  wire              ge_w        = (dbl_w >= dec_p10_r);
  wire [BODY_W-1:0] frac_nxt_w  = {frac_r[BODY_W-2:0], ge_w};
  wire              conv_last_w = (conv_cnt_r == 5'(BODY_W - 1));
  wire [REG_W-1:0]  dec_mag_w   = {1'b0, frac_nxt_w} & hi_mask;
  // truncation in the doubling loop leaves the last bit uncertain
  wire [REG_W-1:0]  dec_val_w   = y_r[SIGN_POS] ? REG_W'(~dec_mag_w + 1'b1) : dec_mag_w;
  wire [REG_W-1:0]  dec_y_w     = (dec_val_w & hi_mask) | {1'b0, mark_w};
  wire              digit_ok_w  = dec_ev && (dec_cnt_r < 4'(DEC_DIGITS)) &&
                                  (digit_s < DEC_RADIX);
  wire              in_fill     = (state_r == ST_FILL);

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      y_r       <= '0;
      grp_cnt_r <= '0;
    end else if (in_fill && clr_ev) begin
      y_r       <= '0;
      grp_cnt_r <= '0;
    end else if (in_fill && key_ev && (grp_cnt_r < 4'(GRP_MAX))) begin
      y_r[BODY_W-1:0] <= body_w | key_shift_w;
      grp_cnt_r       <= grp_cnt_r + 1'b1;
    end else if (in_fill && sign_ev) begin
      y_r[SIGN_POS] <= ~y_r[SIGN_POS];
    end else if ((state_r == ST_CONV) && conv_last_w) begin
      y_r <= dec_y_w;
    end else if (run_tick && !y_ovf_w) begin
      y_r <= y_sum_w[REG_W-1:0] | {1'b0, mark_w};
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      dec_num_r <= '0;
      dec_p10_r <= DEC_ONE;
      dec_cnt_r <= '0;
    end else if ((in_fill && clr_ev) || ((state_r == ST_CONV) && conv_last_w)) begin
      dec_num_r <= '0;
      dec_p10_r <= DEC_ONE;
      dec_cnt_r <= '0;
    end else if (in_fill && digit_ok_w) begin
      dec_num_r <= 28'(dec_num_r * DEC_RADIX + digit_s);
      dec_p10_r <= 28'(dec_p10_r * DEC_RADIX);
      dec_cnt_r <= dec_cnt_r + 1'b1;
    end else if (state_r == ST_CONV) begin
      dec_num_r <= ge_w ? 28'(dbl_w - dec_p10_r) : dbl_w;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      frac_r     <= '0;
      conv_cnt_r <= '0;
    end else if (state_r == ST_CONV) begin
      frac_r     <= frac_nxt_w;
      conv_cnt_r <= conv_cnt_r + 1'b1;
    end else begin
      frac_r     <= '0;
      conv_cnt_r <= '0;
    end
  end

  // ****************************************
  // control
  // ****************************************
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_FILL: begin
        if (load_ev) state_nxt = ST_CONV;
        else if (run_s && len_ok_w) state_nxt = ST_RUN;
      end
      ST_CONV: begin
        if (conv_last_w) state_nxt = ST_FILL;
      end
      ST_RUN: begin
        if (!run_s || !len_ok_w) state_nxt = ST_FILL;
        else if (tick_r && y_ovf_w && auto_halt_s) state_nxt = ST_HALT;
      end
      ST_HALT: begin
        if (!run_s) state_nxt = ST_FILL;
      end
      default: state_nxt = ST_FILL;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_r <= ST_FILL;
      r_r     <= R_HALF;
      ovf_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (in_fill) r_r <= R_HALF;
      else if (run_tick) r_r <= r_nxt_w;
      if (run_tick && y_ovf_w) ovf_r <= 1'b1;
      else if (in_fill && clr_ev) ovf_r <= 1'b0;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  wire signed [14:0] dac_sum_w = $signed(DAC_LEVEL) + (run_tick && dz_pos_w ? 15'sh0001 :
                                 run_tick && dz_neg_w ? 15'sh7FFF : 15'sh0000);
  wire signed [14:0] dac_nxt_w = (dac_sum_w > DAC_MAX) ? DAC_MAX :
                                 (dac_sum_w < DAC_MIN) ? DAC_MIN : dac_sum_w;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ITER_STB  <= 1'b0;
      OUT_POS_P <= 1'b0;
      OUT_POS_M <= 1'b0;
      OUT_NEG_P <= 1'b0;
      OUT_NEG_M <= 1'b0;
      OVERFLOW  <= 1'b0;
      LEN_FAULT <= 1'b0;
      RUNNING   <= 1'b0;
      Y_READ    <= '0;
      DAC_LEVEL <= '0;
    end else begin
      ITER_STB  <= tick_r;
      // held for the whole next iteration: one iteration of delay
      if (tick_r) begin
        OUT_POS_P <= run_tick && dz_pos_w;
        OUT_POS_M <= run_tick && dz_neg_w;
        OUT_NEG_P <= run_tick && dz_neg_w;
        OUT_NEG_M <= run_tick && dz_pos_w;
      end
      OVERFLOW  <= ovf_r;
      LEN_FAULT <= in_fill && run_s && !len_ok_w;
      RUNNING   <= (state_r == ST_RUN);
      Y_READ    <= y_r;
      DAC_LEVEL <= dac_nxt_w;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  localparam int A_GAP = ITER_CYC - 1;

  default clocking a_clk @(posedge CLK); endclocking
  default disable iff (!RST_B);

  a_iter_period: assert property (tick_r |-> ##1 !tick_r ##[A_GAP:A_GAP] tick_r)
    else $error("iteration period wrong");
  a_marker_form: assert property ((state_r == ST_RUN) |-> (|mark_w) &&
                                  ((y_r & ~hi_mask) == {1'b0, mark_w}))
    else $error("register marker lost");
  a_len_limit: assert property ((state_r == ST_RUN && !len_ok_w) |=> state_r == ST_FILL)
    else $error("register too long while running");
  a_remainder_range: assert property ((state_r == ST_RUN) |-> r_r >= 0 && r_r < R_ONE)
    else $error("remainder out of range");
  a_remainder_start: assert property ($rose(state_r == ST_RUN) |-> r_r == R_HALF)
    else $error("remainder not one half at start");
  a_out_mirror: assert property (OUT_NEG_P == OUT_POS_M && OUT_NEG_M == OUT_POS_P)
    else $error("negative output not mirrored");
  a_out_ternary: assert property (!(OUT_POS_P && OUT_POS_M))
    else $error("output both plus and minus");
  a_out_timing: assert property ($changed(OUT_POS_P) || $changed(OUT_POS_M) |->
                                 $past(tick_r))
    else $error("output changed off iteration edge");
  a_ovf_halt: assert property ((run_tick && y_ovf_w && auto_halt_s && run_s && len_ok_w)
                               |=> state_r == ST_HALT ##1 OVERFLOW)
    else $error("overflow did not halt");
  a_dac_range: assert property ($signed(DAC_LEVEL) <= DAC_MAX &&
                                $signed(DAC_LEVEL) >= DAC_MIN)
    else $error("converter level out of range");
  a_first_group: assert property ((in_fill && key_ev && !clr_ev && grp_cnt_r == '0) |=>
                                  y_r[BODY_W-1:GRP_TOP] == $past(key_val_s | y_r[BODY_W-1:GRP_TOP]))
    else $error("first octal group misplaced");

  c_plus_out: cover property (run_tick && dz_pos_w);
  c_minus_out: cover property (run_tick && dz_neg_w);
  c_overflow: cover property (run_tick && y_ovf_w);
  c_decimal: cover property (state_r == ST_CONV && conv_last_w);

endmodule : dda_integrator

// ### verification/dda_neighbour.sv
module dda_neighbour
  import dda_pkg::*;
(
  // ****
  // clock, reset and pacing
  // ****
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              iter_stb,
  // wanted increment for the next iteration
  input  wire logic signed [3:0] dx_want,
  // increment lines toward the integrator
  output logic                   dx_p,
  output logic                   dx_m
);
  timeunit 1ns;
  timeprecision 1ps;

  // a neighbour only moves at an iteration boundary, so a level holds a whole step
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dx_p <= 1'b0;
      dx_m <= 1'b0;
    end else if (iter_stb) begin
      dx_p <= #1 (dx_want == INC_PLUS);
      dx_m <= #1 (dx_want == INC_MINUS);
    end
  end
endmodule : dda_neighbour

// ### verification/tb_top.sv
module tb_top import dda_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DLY = 1;

  // ****
  // stimulus and observed signals
  // ****
  logic              clk, rst_b, run, sum_en, sec_is_time, auto_halt;
  logic              key_stb, sign_stb, clear_stb;
  logic              const_mode, dec_stb, dec_load;
  logic [3:0]        dec_digit;
  logic [2:0]        key_val;
  logic [1:0]        sec_p, sec_m;
  logic [5:0]        sum_p, sum_m;
  logic signed [3:0] dx_want;
  logic              pri_p, pri_m, iter_stb, overflow, len_fault, running;
  logic              pos_p, pos_m, neg_p, neg_m;
  logic [29:0]       y_read, y_exp;
  logic [14:0]       dac_level;
  int                n_errors, checked;

  dda_neighbour dda_neighbour_i (.clk(clk), .rst_b(rst_b), .iter_stb(iter_stb),
    .dx_want(dx_want), .dx_p(pri_p), .dx_m(pri_m));

  dda_integrator dda_integrator_i (.CLK(clk), .RST_B(rst_b), .RUN(run), .SUM_EN(sum_en),
    .SEC_IS_TIME(sec_is_time), .CONST_MODE(const_mode), .AUTO_HALT(auto_halt), .PRI_P(pri_p),
    .PRI_M(pri_m), .SEC_P(sec_p), .SEC_M(sec_m), .SUM_P(sum_p), .SUM_M(sum_m),
    .KEY_STB(key_stb), .KEY_VAL(key_val), .SIGN_STB(sign_stb), .CLEAR_STB(clear_stb),
    .DEC_STB(dec_stb), .DEC_DIGIT(dec_digit), .DEC_LOAD(dec_load), .ITER_STB(iter_stb),
    .OUT_POS_P(pos_p), .OUT_POS_M(pos_m), .OUT_NEG_P(neg_p), .OUT_NEG_M(neg_m),
    .OVERFLOW(overflow), .LEN_FAULT(len_fault), .RUNNING(running), .Y_READ(y_read),
    .DAC_LEVEL(dac_level));

  always #12.5 clk = ~clk;

  // ****
  // shared helpers
  // ****
  task automatic wrap_up;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input string what, input logic [29:0] exp, input logic [29:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chk_bit(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #DLY;
  endtask : tick

  // returns just after the edge that raised the iteration pulse
  task automatic wait_iter;
    bit seen;
    seen = 1'b0;
    for (int i = 0; i < 500 && !seen; i++) begin
      tick(1);
      if (iter_stb === 1'b1) seen = 1'b1;
    end
    if (!seen) begin
      n_errors++;
      $display("[ERR] iteration pulse expected 1 seen 0");
      wrap_up();
    end
  endtask : wait_iter

  // keys and strobes pass a synchroniser, so each level is held well past three edges
  task automatic press(input logic [2:0] v);
    key_val = v;
    key_stb = 1'b1;
    tick(5);
    key_stb = 1'b0;
    tick(5);
  endtask : press

  task automatic strobe(input bit sign);
    if (sign) sign_stb = 1'b1;
    else clear_stb = 1'b1;
    tick(5);
    sign_stb = 1'b0;
    clear_stb = 1'b0;
    tick(5);
  endtask : strobe

  // digits and the load strobe pass the same synchroniser as the keys
  task automatic dec_key(input logic [3:0] d, input bit load);
    dec_digit = d;
    if (load) dec_load = 1'b1;
    else dec_stb = 1'b1;
    tick(5);
    dec_stb = 1'b0;
    dec_load = 1'b0;
    tick(5);
  endtask : dec_key

  function automatic logic [29:0] place(input logic [29:0] y, input int k, input logic [2:0] v);
    if (k < 9) y[28-3*k -: 3] = v;
    else y[1:0] = v[2:1];
    return y;
  endfunction : place

  task automatic set_run(input logic r);
    run = r;
    tick(8);
  endtask : set_run

  // ****
  // scenarios
  // ****
  task automatic t_reset;
    int c;
    chk_bit("running", 1'b0, running);
    chk_bit("overflow", 1'b0, overflow);
    chk("y", 30'h0000_0000, y_read);
    wait_iter();
    for (c = 1; c < 600; c++) begin
      tick(1);
      if (iter_stb === 1'b1) break;
    end
    chk("iteration period", 30'(ITER_CYC), 30'(c));
    $display("test reset done");
  endtask : t_reset

  task automatic t_octal;
    strobe(0);
    y_exp = 30'h0000_0000;
    for (int k = 0; k < 8; k++) begin
      press(3'(7 - k));
      y_exp = place(y_exp, k, 3'(7 - k));
    end
    chk("octal fill", y_exp, y_read);
    strobe(1);
    y_exp[SIGN_POS] = 1'b1;
    chk("sign fill", y_exp, y_read);
    $display("test octal done");
  endtask : t_octal

  task automatic t_len;
    strobe(0);
    sec_is_time = 1'b1;
    set_run(1'b1);
    chk_bit("fault empty", 1'b1, len_fault);
    set_run(1'b0);
    y_exp = 30'h0000_0000;
    for (int k = 0; k < 10; k++) begin
      press((k == 9) ? 3'h4 : 3'h0);
      y_exp = place(y_exp, k, (k == 9) ? 3'h4 : 3'h0);
    end
    chk("tenth group", y_exp, y_read);
    sec_is_time = 1'b0;
    set_run(1'b1);
    chk_bit("fault other", 1'b1, len_fault);
    chk_bit("running other", 1'b0, running);
    set_run(1'b0);
    sec_is_time = 1'b1;
    set_run(1'b1);
    chk_bit("running time", 1'b1, running);
    set_run(1'b0);
    $display("test length done");
  endtask : t_len

  // y = 0.875: remainder from one half overflows on each of three +1 steps;
  // the second key only places the marker
  task automatic t_run;
    strobe(0);
    press(3'h7);
    press(3'h4);
    y_exp = 30'h1E00_0000;
    sec_p = 2'b11;
    sec_m = 2'b11;
    set_run(1'b1);
    chk_bit("running", 1'b1, running);
    wait_iter();
    chk_bit("idle out", 1'b0, pos_p);
    dx_want = INC_PLUS;
    for (int i = 0; i < 3; i++) begin
      wait_iter();
      if (i == 2) dx_want = INC_ZERO;
      chk_bit("pos plus", 1'b1, pos_p);
      chk_bit("pos minus", 1'b0, pos_m);
      chk_bit("neg plus", 1'b0, neg_p);
      chk_bit("neg minus", 1'b1, neg_m);
    end
    tick(3);
    chk("dac", 30'h0000_0003, 30'(dac_level));
    wait_iter();
    chk_bit("zero out", 1'b0, pos_p);
    chk_bit("zero neg", 1'b0, neg_m);
    chk("y held", y_exp, y_read);
    // both secondaries at -1: y drops by two steps of its lowest computing bit
    sec_p = 2'b00;
    wait_iter();
    tick(3);
    chk("y two secondaries", 30'h1600_0000, y_read);
    sec_m = 2'b00;
    set_run(1'b0);
    chk_bit("stopped", 1'b0, running);
    $display("test run done");
  endtask : t_run

  task automatic t_ovf;
    strobe(0);
    y_exp = 30'h0000_0000;
    for (int k = 0; k < 10; k++) begin
      press((k == 9) ? 3'h4 : 3'h7);
      y_exp = place(y_exp, k, (k == 9) ? 3'h4 : 3'h7);
    end
    sum_en = 1'b1;
    sum_p = 6'b00_1001;
    sum_m = 6'b00_0001;
    auto_halt = 1'b1;
    const_mode = 1'b1;
    set_run(1'b1);
    chk_bit("running", 1'b1, running);
    wait_iter();
    tick(3);
    chk_bit("constant no overflow", 1'b0, overflow);
    chk_bit("constant running", 1'b1, running);
    chk("constant y kept", y_exp, y_read);
    const_mode = 1'b0;
    wait_iter();
    tick(3);
    chk_bit("overflow", 1'b1, overflow);
    chk("y kept", y_exp, y_read);
    chk_bit("halted", 1'b0, running);
    sum_en = 1'b0;
    sum_p = 6'b00_0000;
    sum_m = 6'b00_0000;
    set_run(1'b0);
    strobe(0);
    chk_bit("overflow cleared", 1'b0, overflow);
    $display("test overflow done");
  endtask : t_ovf

  // -0.25 entered in decimal: octal keys place the marker, the sign is set first,
  // and a digit above nine is refused
  task automatic t_dec;
    strobe(0);
    press(3'h0);
    press(3'h1);
    strobe(1);
    dec_key(4'h2, 1'b0);
    dec_key(4'h5, 1'b0);
    dec_key(4'hA, 1'b0);
    dec_key(4'h0, 1'b1);
    tick(30);
    chk("decimal fill", 30'h3880_0000, y_read);
    $display("test decimal done");
  endtask : t_dec

  // ****
  // main sequence
  // ****
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    {run, sum_en, sec_is_time, auto_halt, key_stb, sign_stb, clear_stb} = '0;
    {const_mode, dec_stb, dec_load} = '0;
    dec_digit = 4'h0;
    key_val = 3'h0;
    sec_p = 2'b00;
    sec_m = 2'b00;
    sum_p = 6'b00_0000;
    sum_m = 6'b00_0000;
    dx_want = INC_ZERO;
    n_errors = 0;
    checked = 0;
    repeat (12) @(posedge clk);
    #DLY;
    rst_b = 1'b1;
    tick(3);
    t_reset();
    t_octal();
    t_len();
    t_run();
    t_ovf();
    t_dec();
    wrap_up();
  end
endmodule : tb_top
